/* rtl/ext_map_map.svh */
// Index, offset and field definitions for the extension mapping register bank
`ifndef EXT_MAP_MAP_SVH
`define EXT_MAP_MAP_SVH

`define IDX_PALETTE_DAC    7'h06
`define IDX_LIN_BASE_LO    7'h08
`define IDX_LIN_BASE_HI    7'h09
`define IDX_VCACHE_MODE    7'h0A
`define IDX_CPU_PAGING     7'h0B
`define IDX_START_TOP      7'h0C
`define IDX_AUX_OFFSET     7'h0D
`define IDX_TEXT_MODE      7'h0E
`define IDX_SW_FLAGS0      7'h0F
`define IDX_LOW_MAP        7'h10
`define IDX_HIGH_MAP       7'h11
`define IDX_EMULATION      7'h14
`define IDX_WRITE_PROT     7'h15
`define IDX_VERT_OVF       7'h16

// Writable bit masks; all other bits read zero
`define MSK_PALETTE_DAC    8'h1F
`define MSK_LIN_BASE_LO    8'hC0
`define MSK_LIN_BASE_HI    8'hFF
`define MSK_VCACHE_MODE    8'h7F
`define MSK_CPU_PAGING     8'hD7
`define MSK_START_TOP      8'h5F
`define MSK_AUX_OFFSET     8'h04
`define MSK_TEXT_MODE      8'h0D
`define MSK_SW_FLAGS0      8'hFF
`define MSK_LOW_MAP        8'hFF
`define MSK_HIGH_MAP       8'hFF
`define MSK_EMULATION      8'hA0
`define MSK_WRITE_PROT     8'h80
`define MSK_VERT_OVF       8'h57

`define RST_REG            8'h00
`define RST_INDEX          7'h00

// Field positions
`define B_DAC_OFF          1
`define B_DEPTH_LO         2
`define B_DEPTH_HI         3
`define B_OVERLAY          4
`define B_MAP_MODE         0
`define B_DUAL_MAP         1
`define B_ADDR_DIV4        2
`define B_LINEAR           4
`define B_WORD_SWAP        6
`define B_BYTE_SWAP        7
`define B_LOW_OVF          4
`define B_HIGH_OVF         6
`define B_OFFSET_MSB       2
`define B_RETRACE_SRC      5
`define B_IRQ_FUNC         7
`define B_OVERSCAN_WP      7
`define B_VTOTAL10         0
`define B_VDEE10           1
`define B_VSS10            2
`define B_VBS10            4
`define B_LCMP10           6

// Memory sizes from the memory configuration field
`define MEMCFG_512K        2'h0
`define MEMCFG_1M          2'h1
`define MEMCFG_2M          2'h2

// Legacy VGA window high address bits A19:17 = 101
`define VGA_WIN_A19_17     3'h5

`endif

/* rtl/ext_map_pkg.sv */
// Types shared by the extension mapping register bank
package ext_map_pkg;

	typedef enum logic [1:0] {
		depth_4_8,
		depth_15,
		depth_24,
		depth_16
	} color_depth_e;

	typedef enum logic [1:0] {
		irq_tristate,
		irq_drive_low,
		irq_drive_high
	} irq_mode_e;

endpackage

/* rtl/ext_map_regs.sv */
// Indexed extension register bank with frame buffer decode and lane swapping
//
// Operation
// - Index port selects register, data port accesses it
// - DAC disable tri-states RGB and powers down
// - Two-bit colour depth selects pixel format
// - Bit 4 enables colour key overlay
// - Local bus base matches A31:24 and A23:22
// - Upper 2MB of linear region is registers
// - Unpopulated frame buffer accesses accepted, discarded
// - PCI uses config base, 4MB window
// - Video cache mode fields; bit 7 kept zero
// - Mapping mode bit selects extended 512K mapping
// - Dual map bit selects two windows
// - Address divide bit divides CPU address by four
// - Linear mode compares 10-bit base to A31:22
// - Non-linear mode decodes A0000-BFFFF from A19:17
// - Word and byte lane swap bits
// - Start address top gives high display start bits
// - Map overflow bits are ninth map base bit
// - Offset MSB extends line offset to 4095
// - Text control: font scramble, non-blink, xor cursor
// - Low map base window selection
// - High map base window selection
// - Retrace status source: pin or controller
// - Interrupt pin function per bit 7
// - Write protect blocks overscan colour writes
// - Vertical overflow gives bit 10 of vertical total and display end
`timescale 1ns/100ps
`default_nettype none
`include "ext_map_map.svh"

module ext_map_regs (
	input  wire logic        mclk,
	input  wire logic        rst,
	// Index/data port pair
	input  wire logic        idx_wr,
	input  wire logic [7:0]  idx_wdata,
	output logic      [7:0]  idx_rdata,
	input  wire logic        dat_wr,
	input  wire logic        dat_rd,
	input  wire logic [7:0]  dat_wdata,
	output logic      [7:0]  dat_rdata,
	// Environment
	input  wire logic        pci_mode,
	input  wire logic [9:0]  pci_frame_base,
	input  wire logic [1:0]  mem_config,
	input  wire logic [1:0]  graphics_misc_map,
	// Memory access address and data
	input  wire logic [31:0] cpu_addr,
	input  wire logic [31:0] cpu_wdata,
	output logic             fb_hit,
	output logic             mmio_hit,
	output logic             fb_discard,
	output logic [20:0]      fb_offset,
	output logic [31:0]      fb_wdata_swapped,
	// Display and video controls
	output logic             dac_outputs_oe,
	output logic             dac_powerdown,
	output logic [1:0]       color_depth,
	output logic             overlay_enable,
	input  wire logic        vafc_mode,
	input  wire logic        video_ready_input,
	output logic             overlay_qualify,
	output logic [7:0]       vcache_mode,
	output logic             extended_map_mode,
	output logic             dual_map,
	output logic             addr_div4,
	output logic [3:0]       start_addr_top,
	output logic [8:0]       low_map_base,
	output logic [8:0]       high_map_base,
	output logic             line_offset_msb,
	output logic [2:0]       text_ctrl,
	output logic [1:0]       vert_overflow_10,
	// Retrace status and interrupt pin
	input  wire logic        vretrace_pin,
	input  wire logic        vretrace_ctl,
	output logic             vretrace_status,
	input  wire logic        irq_enabled,
	input  wire logic        irq_active,
	output logic             irq_out,
	output logic             irq_oe,
	// Overscan colour write gating
	input  wire logic        overscan_wr_req,
	output logic             overscan_wr_allow
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [6:0] index_q;
	logic [7:0] pal_q, lbl_q, lbh_q, vcm_q, pag_q, sat_q, aux_q;
	logic [7:0] txt_q, swf_q, lmap_q, hmap_q, emu_q, wp_q, vov_q;

	// Mask for the register at an index; zero for unmapped
	function automatic logic [7:0] reg_mask(input logic [6:0] idx);
		unique case (idx)
			`IDX_PALETTE_DAC: reg_mask = `MSK_PALETTE_DAC;
			`IDX_LIN_BASE_LO: reg_mask = `MSK_LIN_BASE_LO;
			`IDX_LIN_BASE_HI: reg_mask = `MSK_LIN_BASE_HI;
			`IDX_VCACHE_MODE: reg_mask = `MSK_VCACHE_MODE;
			`IDX_CPU_PAGING:  reg_mask = `MSK_CPU_PAGING;
			`IDX_START_TOP:   reg_mask = `MSK_START_TOP;
			`IDX_AUX_OFFSET:  reg_mask = `MSK_AUX_OFFSET;
			`IDX_TEXT_MODE:   reg_mask = `MSK_TEXT_MODE;
			`IDX_SW_FLAGS0:   reg_mask = `MSK_SW_FLAGS0;
			`IDX_LOW_MAP:     reg_mask = `MSK_LOW_MAP;
			`IDX_HIGH_MAP:    reg_mask = `MSK_HIGH_MAP;
			`IDX_EMULATION:   reg_mask = `MSK_EMULATION;
			`IDX_WRITE_PROT:  reg_mask = `MSK_WRITE_PROT;
			`IDX_VERT_OVF:    reg_mask = `MSK_VERT_OVF;
			default:          reg_mask = `RST_REG;
		endcase
	endfunction

	// Swap byte lanes of a word
	function automatic logic [31:0] lane_swap(input logic [31:0] d, input logic ws,
			input logic bs);
		logic [31:0] w;
		w = ws ? {d[23:16], d[31:24], d[7:0], d[15:8]} : d;
		lane_swap = bs ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	endfunction

	logic [7:0] wval;
	assign wval = dat_wdata & reg_mask(index_q);

	// Index register, top bit reserved
	always_ff @(posedge mclk) begin
		if (rst) begin
			index_q <= `RST_INDEX;
		end else if (idx_wr) begin
			index_q <= idx_wdata[6:0];
		end
	end

	// Data port writes into the selected register
	always_ff @(posedge mclk) begin
		if (rst) begin
			pal_q  <= `RST_REG;
			lbl_q  <= `RST_REG;
			lbh_q  <= `RST_REG;
			vcm_q  <= `RST_REG;
			pag_q  <= `RST_REG;
			sat_q  <= `RST_REG;
			aux_q  <= `RST_REG;
			txt_q  <= `RST_REG;
			swf_q  <= `RST_REG;
			lmap_q <= `RST_REG;
			hmap_q <= `RST_REG;
			emu_q  <= `RST_REG;
			wp_q   <= `RST_REG;
			vov_q  <= `RST_REG;
		end else if (dat_wr) begin
			unique case (index_q)
				`IDX_PALETTE_DAC: pal_q  <= wval;
				`IDX_LIN_BASE_LO: lbl_q  <= wval;
				`IDX_LIN_BASE_HI: lbh_q  <= wval;
				`IDX_VCACHE_MODE: vcm_q  <= wval;
				`IDX_CPU_PAGING:  pag_q  <= wval;
				`IDX_START_TOP:   sat_q  <= wval;
				`IDX_AUX_OFFSET:  aux_q  <= wval;
				`IDX_TEXT_MODE:   txt_q  <= wval;
				`IDX_SW_FLAGS0:   swf_q  <= wval;
				`IDX_LOW_MAP:     lmap_q <= wval;
				`IDX_HIGH_MAP:    hmap_q <= wval;
				`IDX_EMULATION:   emu_q  <= wval;
				`IDX_WRITE_PROT:  wp_q   <= wval;
				`IDX_VERT_OVF:    vov_q  <= wval;
				default:          ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		unique case (index_q)
			`IDX_PALETTE_DAC: rd_mux = pal_q;
			`IDX_LIN_BASE_LO: rd_mux = lbl_q;
			`IDX_LIN_BASE_HI: rd_mux = lbh_q;
			`IDX_VCACHE_MODE: rd_mux = vcm_q;
			`IDX_CPU_PAGING:  rd_mux = pag_q;
			`IDX_START_TOP:   rd_mux = sat_q;
			`IDX_AUX_OFFSET:  rd_mux = aux_q;
			`IDX_TEXT_MODE:   rd_mux = txt_q;
			`IDX_SW_FLAGS0:   rd_mux = swf_q;
			`IDX_LOW_MAP:     rd_mux = lmap_q;
			`IDX_HIGH_MAP:    rd_mux = hmap_q;
			`IDX_EMULATION:   rd_mux = emu_q;
			`IDX_WRITE_PROT:  rd_mux = wp_q;
			`IDX_VERT_OVF:    rd_mux = vov_q;
			default:          rd_mux = `RST_REG;
		endcase
	end

	// Registered read data; index readback has top bit zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			idx_rdata <= `RST_REG;
			dat_rdata <= `RST_REG;
		end else begin
			idx_rdata <= {1'b0, index_q};
			if (dat_rd) begin
				dat_rdata <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// Memory address decode
	// ----------------------------------------------------------------
	logic        lin_match, vga_match, in_region, upper_half, populated;
	logic [9:0]  base4m;
	logic [20:0] raw_off;
	always_comb begin
		base4m    = pci_mode ? pci_frame_base : {lbh_q, lbl_q[7:6]};
		lin_match = (cpu_addr[31:22] == base4m);
		vga_match  = (cpu_addr[19:17] == `VGA_WIN_A19_17);
		upper_half = cpu_addr[21];
		unique case (mem_config)
			`MEMCFG_512K: populated = (cpu_addr[20:19] == 2'b00);
			`MEMCFG_1M:   populated = !cpu_addr[20];
			default:      populated = 1'b1;
		endcase
		in_region = (pag_q[`B_LINEAR] || pci_mode) ? lin_match : vga_match;
		raw_off   = pag_q[`B_ADDR_DIV4] ? {2'b00, cpu_addr[20:2]} : cpu_addr[20:0];
	end

	// Registered decode outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			fb_hit     <= 1'b0;
			mmio_hit   <= 1'b0;
			fb_discard <= 1'b0;
			fb_offset  <= '0;
		end else begin
			mmio_hit   <= in_region && (pag_q[`B_LINEAR] || pci_mode) && upper_half;
			fb_hit     <= in_region && !((pag_q[`B_LINEAR] || pci_mode) && upper_half);
			fb_discard <= in_region && (pag_q[`B_LINEAR] || pci_mode) && !upper_half
				&& !populated;
			fb_offset  <= raw_off;
		end
	end

	// Lane swap of frame buffer write data
	always_ff @(posedge mclk) begin
		if (rst) begin
			fb_wdata_swapped <= '0;
		end else begin
			fb_wdata_swapped <= lane_swap(cpu_wdata, pag_q[`B_WORD_SWAP],
				pag_q[`B_BYTE_SWAP]);
		end
	end

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			dac_outputs_oe    <= 1'b1;
			dac_powerdown     <= 1'b0;
			color_depth       <= 2'b00;
			overlay_enable    <= 1'b0;
			overlay_qualify   <= 1'b0;
			vcache_mode       <= `RST_REG;
			extended_map_mode <= 1'b0;
			dual_map          <= 1'b0;
			addr_div4         <= 1'b0;
			start_addr_top    <= '0;
			low_map_base      <= '0;
			high_map_base     <= '0;
			line_offset_msb   <= 1'b0;
			text_ctrl         <= '0;
			vert_overflow_10  <= '0;
		end else begin
			dac_outputs_oe    <= !pal_q[`B_DAC_OFF];
			dac_powerdown     <= pal_q[`B_DAC_OFF];
			color_depth       <= pal_q[`B_DEPTH_HI:`B_DEPTH_LO];
			overlay_enable    <= pal_q[`B_OVERLAY];
			overlay_qualify   <= pal_q[`B_OVERLAY]
				&& (!vafc_mode || video_ready_input);
			vcache_mode       <= vcm_q;
			extended_map_mode <= pag_q[`B_MAP_MODE];
			dual_map          <= pag_q[`B_DUAL_MAP];
			addr_div4         <= pag_q[`B_ADDR_DIV4];
			start_addr_top    <= sat_q[3:0];
			low_map_base      <= {sat_q[`B_LOW_OVF], lmap_q};
			// High map only meaningful in dual mode with legal window
			high_map_base     <= (pag_q[`B_DUAL_MAP] && !graphics_misc_map[1])
				? {sat_q[`B_HIGH_OVF], hmap_q} : '0;
			line_offset_msb   <= aux_q[`B_OFFSET_MSB];
			text_ctrl         <= {txt_q[3], txt_q[2], txt_q[0]};
			vert_overflow_10  <= {vov_q[`B_VDEE10], vov_q[`B_VTOTAL10]};
		end
	end

	// Retrace status source and overscan write gate
	always_ff @(posedge mclk) begin
		if (rst) begin
			vretrace_status   <= 1'b0;
			overscan_wr_allow <= 1'b0;
		end else begin
			vretrace_status   <= emu_q[`B_RETRACE_SRC] ? vretrace_ctl : vretrace_pin;
			overscan_wr_allow <= overscan_wr_req && !wp_q[`B_OVERSCAN_WP];
		end
	end

	// Interrupt pin function
	ext_map_pkg::irq_mode_e irq_mode;
	always_comb begin
		if (!emu_q[`B_IRQ_FUNC] || !irq_enabled) begin
			irq_mode = ext_map_pkg::irq_tristate;
		end else if (irq_active) begin
			irq_mode = ext_map_pkg::irq_drive_high;
		end else begin
			irq_mode = ext_map_pkg::irq_drive_low;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_out <= 1'b0;
			irq_oe  <= 1'b0;
		end else begin
			irq_oe  <= (irq_mode != ext_map_pkg::irq_tristate);
			irq_out <= (irq_mode == ext_map_pkg::irq_drive_high);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_write_dac_off;
		dat_wr && index_q == `IDX_PALETTE_DAC && dat_wdata[`B_DAC_OFF];
	endsequence

	property p_dac_off;
		@(posedge mclk) disable iff (rst)
		s_write_dac_off ##1 !dat_wr [*2] |-> dac_powerdown && !dac_outputs_oe;
	endproperty
	a_dac_off: assert property (p_dac_off) else $error("DAC not powered down");

	property p_index_top_zero;
		@(posedge mclk) disable iff (rst)
		idx_wr |=> ##1 idx_rdata[7] == 1'b0 && idx_rdata[6:0] == $past(idx_wdata[6:0], 2);
	endproperty
	a_index_top_zero: assert property (p_index_top_zero) else $error("Index readback bad");

	property p_readback;
		@(posedge mclk) disable iff (rst)
		dat_wr && !idx_wr ##1 dat_rd && !dat_wr && !idx_wr
			|=> dat_rdata == ($past(dat_wdata, 2) & reg_mask(index_q));
	endproperty
	a_readback: assert property (p_readback) else $error("Readback mismatch");

	property p_swflags;
		@(posedge mclk) disable iff (rst)
		dat_wr && index_q == `IDX_SW_FLAGS0 |=> swf_q == $past(dat_wdata);
	endproperty
	a_swflags: assert property (p_swflags) else $error("Flags not stored");

	property p_overscan;
		@(posedge mclk) disable iff (rst)
		wp_q[`B_OVERSCAN_WP] && $stable(wp_q) |=> !overscan_wr_allow;
	endproperty
	a_overscan: assert property (p_overscan) else $error("Overscan write leaked");

	property p_irq_off;
		@(posedge mclk) disable iff (rst)
		!emu_q[`B_IRQ_FUNC] |=> !irq_oe;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("Interrupt pin driven");

	property p_irq_high;
		@(posedge mclk) disable iff (rst)
		emu_q[`B_IRQ_FUNC] && irq_enabled && irq_active |=> irq_oe && irq_out;
	endproperty
	a_irq_high: assert property (p_irq_high) else $error("Interrupt not high");

	property p_retrace;
		@(posedge mclk) disable iff (rst)
		emu_q[`B_RETRACE_SRC] |=> vretrace_status == $past(vretrace_ctl);
	endproperty
	a_retrace: assert property (p_retrace) else $error("Retrace source wrong");

	property p_mmio;
		@(posedge mclk) disable iff (rst)
		pag_q[`B_LINEAR] && !pci_mode && cpu_addr[31:22] == {lbh_q, lbl_q[7:6]}
			&& cpu_addr[21] |=> mmio_hit && !fb_hit;
	endproperty
	a_mmio: assert property (p_mmio) else $error("Upper half not register space");

endmodule
`default_nettype wire

/* dv/host_model.sv */
// Host processor model driving the index and data ports
`timescale 1ns/100ps
`default_nettype none
`include "ext_map_map.svh"
module host_model (
	input  wire logic       mclk,
	output logic            idx_wr,
	output logic [7:0]      idx_wdata,
	output logic            dat_wr,
	output logic            dat_rd,
	output logic [7:0]      dat_wdata,
	input  wire logic [7:0] dat_rdata
);
	int gap = 0;

	// Quiet port at time zero
	initial begin
		{idx_wr, dat_wr, dat_rd} = '0;
		{idx_wdata, dat_wdata} = '0;
	end

	// Index write after optional idle cycles; released bus shows inverse
	task automatic put_index(input logic [7:0] i);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		idx_wr    <= 1'b1;
		idx_wdata <= i;
		@(posedge mclk);
		idx_wr    <= 1'b0;
		idx_wdata <= ~i;
	endtask

	// Select then write; cache diagnostic bit always sent clear
	task automatic write_reg(input logic [6:0] i, input logic [7:0] d);
		logic [7:0] x;
		x = d;
		if (i == `IDX_VCACHE_MODE) x[5] = 1'b0;
		put_index({1'b0, i});
		dat_wr    <= 1'b1;
		dat_wdata <= x;
		@(posedge mclk);
		dat_wr    <= 1'b0;
		dat_wdata <= ~x;
	endtask

	// Select then read; data taken once it has settled
	task automatic read_reg(input logic [6:0] i, output logic [7:0] d);
		put_index({1'b0, i});
		dat_rd <= 1'b1;
		@(posedge mclk);
		dat_rd <= 1'b0;
		@(posedge mclk);
		#1;
		d = dat_rdata;
	endtask

	// Write at the current index, then read it on the very next edge
	task automatic write_read(input logic [7:0] d, output logic [7:0] r);
		@(posedge mclk);
		dat_wr    <= 1'b1;
		dat_wdata <= d;
		@(posedge mclk);
		dat_wr    <= 1'b0;
		dat_wdata <= ~d;
		dat_rd    <= 1'b1;
		@(posedge mclk);
		dat_rd    <= 1'b0;
		@(posedge mclk);
		#1;
		r = dat_rdata;
	endtask
endmodule
`default_nettype wire

/* dv/vga_extension_mapping_regs_tb.sv */
// Self-checking bench for the extension mapping register bank
`timescale 1ns/100ps
`default_nettype none
`include "ext_map_map.svh"
module vga_extension_mapping_regs_tb;
	logic        mclk, rst, idx_wr, dat_wr, dat_rd, pci_mode, fb_hit, mmio_hit;
	logic        fb_discard, dac_outputs_oe, dac_powerdown, overlay_enable, vafc_mode;
	logic        video_ready_input, overlay_qualify, extended_map_mode, dual_map;
	logic        addr_div4, line_offset_msb, vretrace_pin, vretrace_ctl;
	logic        vretrace_status, irq_enabled, irq_active, irq_out, irq_oe;
	logic        overscan_wr_req, overscan_wr_allow;
	logic [1:0]  mem_config, graphics_misc_map, color_depth, vert_overflow_10;
	logic [2:0]  text_ctrl;
	logic [3:0]  start_addr_top;
	logic [6:0]  ix;
	logic [7:0]  rb;
	logic [7:0]  idx_wdata, idx_rdata, dat_wdata, dat_rdata, vcache_mode;
	logic [8:0]  low_map_base, high_map_base;
	logic [9:0]  pci_frame_base;
	logic [20:0] fb_offset;
	logic [31:0] cpu_addr, cpu_wdata, fb_wdata_swapped, seed, v, base, lim, o, w;
	int          errors, comparisons, cycles;
	int          mdl [128];
	logic [6:0]  itab [15] = '{`IDX_PALETTE_DAC, `IDX_LIN_BASE_LO, `IDX_LIN_BASE_HI,
		`IDX_VCACHE_MODE, `IDX_CPU_PAGING, `IDX_START_TOP, `IDX_AUX_OFFSET,
		`IDX_TEXT_MODE, `IDX_SW_FLAGS0, `IDX_LOW_MAP, `IDX_HIGH_MAP, `IDX_EMULATION,
		`IDX_WRITE_PROT, `IDX_VERT_OVF, 7'h12};
	logic [7:0]  mtab [15] = '{`MSK_PALETTE_DAC, `MSK_LIN_BASE_LO, `MSK_LIN_BASE_HI,
		`MSK_VCACHE_MODE, `MSK_CPU_PAGING, `MSK_START_TOP, `MSK_AUX_OFFSET,
		`MSK_TEXT_MODE, `MSK_SW_FLAGS0, `MSK_LOW_MAP, `MSK_HIGH_MAP, `MSK_EMULATION,
		`MSK_WRITE_PROT, `MSK_VERT_OVF, 8'h00};
	logic [31:0] otab [7] = '{32'h0000_0000, 32'h0007_FFFC, 32'h0008_0000,
		32'h0010_0000, 32'h001F_FFFC, 32'h0020_0000, 32'h0040_0000};

	ext_map_regs u_dut (.*);
	host_model u_host (.*);

	// Free-running clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Cycle ceiling against hangs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			$display("unexpected at %0t: timeout", $time);
			wrap_up();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] mask_of(input logic [6:0] i);
		foreach (itab[k]) if (itab[k] == i) return mtab[k];
		return 8'h00;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, s, g, e);
		end
	endtask

	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask

	// Register write mirrored into the model
	task automatic wr(input logic [6:0] i, input logic [7:0] d);
		mdl[i] = d & mask_of(i) & ((i == `IDX_VCACHE_MODE) ? 8'hDF : 8'hFF);
		u_host.write_reg(i, d);
	endtask

	task automatic rd_chk(input logic [6:0] i);
		logic [7:0] b;
		u_host.read_reg(i, b);
		chk(b, mdl[i], "readback");
	endtask

	task automatic do_reset();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		foreach (mdl[k]) mdl[k] = 0;
		settle();
		chk(dac_outputs_oe, 1, "dac oe reset");
		foreach (itab[k]) rd_chk(itab[k]);
	endtask

	// Random side inputs at a clock edge
	task automatic env();
		@(posedge mclk);
		v = rnd();
		{vretrace_pin, vretrace_ctl, irq_enabled, irq_active} <= v[3:0];
		{overscan_wr_req, vafc_mode, video_ready_input} <= v[6:4];
		graphics_misc_map <= v[8:7];
	endtask

	// Control outputs against the model
	task automatic ctrl_chk();
		logic [7:0] p, b, c, e, t;
		p = mdl[`IDX_PALETTE_DAC][7:0];
		b = mdl[`IDX_CPU_PAGING][7:0];
		c = mdl[`IDX_START_TOP][7:0];
		e = mdl[`IDX_EMULATION][7:0];
		t = mdl[`IDX_TEXT_MODE][7:0];
		chk(dac_outputs_oe, !p[1], "dac oe");
		chk(dac_powerdown, p[1], "dac pd");
		chk(color_depth, p[3:2], "depth");
		chk(overlay_enable, p[4], "overlay");
		chk(overlay_qualify, p[4] & (!vafc_mode | video_ready_input), "qual");
		chk(vcache_mode, mdl[`IDX_VCACHE_MODE], "cache");
		chk(extended_map_mode, b[0], "map mode");
		chk(dual_map, b[1], "dual");
		chk(addr_div4, b[2], "div4");
		chk(start_addr_top, c[3:0], "start");
		chk(low_map_base, {c[4], mdl[`IDX_LOW_MAP][7:0]}, "low map");
		chk(high_map_base, (b[1] && !graphics_misc_map[1]) ?
			{c[6], mdl[`IDX_HIGH_MAP][7:0]} : 9'h000, "high map");
		chk(line_offset_msb, mdl[`IDX_AUX_OFFSET][2], "offs");
		chk(text_ctrl, {t[3], t[2], t[0]}, "text");
		chk(vert_overflow_10, mdl[`IDX_VERT_OVF][1:0], "vovf");
		chk(vretrace_status, e[5] ? vretrace_ctl : vretrace_pin, "retrace");
		chk(irq_oe, e[7] & irq_enabled, "irq oe");
		if (e[7] && irq_enabled) chk(irq_out, irq_active, "irq");
		chk(overscan_wr_allow, overscan_wr_req & !mdl[`IDX_WRITE_PROT][7], "wp");
	endtask

	// Memory decode probe; hit is not judged on discarded accesses
	task automatic probe(input logic [31:0] a, input logic h, mm, ds);
		@(posedge mclk);
		cpu_addr <= a;
		settle();
		if (!ds) chk(fb_hit, h, "hit");
		chk(mmio_hit, mm, "mmio");
		chk(fb_discard, ds, "discard");
	endtask

	task automatic wrap_up();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		seed = 32'h0000_9f70;
		{pci_mode, pci_frame_base, mem_config, graphics_misc_map, cpu_addr, cpu_wdata} = '0;
		{vafc_mode, video_ready_input, vretrace_pin, vretrace_ctl} = '0;
		{irq_enabled, irq_active, overscan_wr_req} = '0;
		do_reset();
		u_host.put_index(8'h8B);
		settle();
		chk(idx_rdata, 8'h0B, "index");
		for (int n = 0; n < 24; n++) begin
			u_host.gap = n % 3;
			env();
			foreach (itab[k]) begin
				v = rnd();
				if (itab[k] == `IDX_PALETTE_DAC) v[3:2] = n[1:0];
				wr(itab[k], v[7:0]);
			end
			settle();
			ctrl_chk();
			foreach (itab[k]) rd_chk(itab[k]);
			// Back-to-back write and read at one index
			ix = itab[n % 15];
			v = rnd() & ((ix == `IDX_VCACHE_MODE) ? 32'h0000_00DF : 32'h0000_00FF);
			mdl[ix] = v[7:0] & mask_of(ix);
			u_host.put_index({1'b0, ix});
			u_host.write_read(v[7:0], rb);
			chk(rb, mdl[ix], "write then read");
		end
		do_reset();
		for (int mc = 0; mc < 3; mc++) for (int pm = 0; pm < 2; pm++) begin
			v = rnd();
			@(posedge mclk);
			mem_config <= mc[1:0];
			pci_mode <= pm[0];
			pci_frame_base <= v[9:0];
			wr(`IDX_LIN_BASE_LO, v[17:10]);
			wr(`IDX_LIN_BASE_HI, v[25:18]);
			wr(`IDX_CPU_PAGING, 8'h10);
			base = pm ? {v[9:0], 22'h0} : {v[25:16], 22'h0};
			lim = 32'h0008_0000 << mc;
			foreach (otab[k]) begin
				o = otab[k];
				probe(base + o, o < lim, o >= 32'h0020_0000 && o < 32'h0040_0000,
					o >= lim && o < 32'h0020_0000);
				if (o < lim) chk(fb_offset, o[20:0], "offset");
			end
			probe(base ^ 32'h8000_0000, 1'b0, 1'b0, 1'b0);
		end
		@(posedge mclk);
		pci_mode <= 1'b0;
		graphics_misc_map <= 2'h0;
		for (int s = 0; s < 3; s++) begin
			v = rnd();
			wr(`IDX_CPU_PAGING, {s == 2, s == 1, 3'h0, s == 0, 2'h0});
			@(posedge mclk);
			cpu_wdata <= v;
			probe(32'h000A_0000, 1'b1, 1'b0, 1'b0);
			w = (s == 1) ? {v[23:16], v[31:24], v[7:0], v[15:8]} :
				(s == 2) ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
			chk(fb_wdata_swapped, w, "swap");
			chk(fb_offset, (s == 0) ? 21'h02_8000 : 21'h0A_0000, "cpu offset");
		end
		probe(32'h000B_FFFC, 1'b1, 1'b0, 1'b0);
		probe(32'h0009_FFFC, 1'b0, 1'b0, 1'b0);
		probe(32'h000C_0000, 1'b0, 1'b0, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
